// *** pdc_pkg.sv ***
// Constants shared by the power-down control block and its pin sampler.
// Assumes one 25 MHz core clock and a synchronous active-high reset.
package pdc_pkg;

    // =====================================================================
    // Pin layout.
    localparam int unsigned IO_W     = 32;
    localparam int unsigned DED_W    = 4;
    localparam int unsigned PIN_W    = IO_W + DED_W;
    localparam int unsigned PD_NUM   = 2;
    localparam int unsigned PD1_IDX  = 6;
    localparam int unsigned PD2_IDX  = 24;

    // =====================================================================
    // Timing.
    localparam int unsigned CLK_PERIOD_NS  = 40;
    localparam int unsigned CAPTURE_MAX_NS = 25;
    localparam int unsigned WAKE_MAX_NS    = 1000;
    localparam int unsigned CAPTURE_MAX_CYC =
        (CAPTURE_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (CAPTURE_MAX_NS / CLK_PERIOD_NS);
    localparam int unsigned WAKE_MAX_CYC =
        (WAKE_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (WAKE_MAX_NS / CLK_PERIOD_NS);
    localparam int unsigned WAKE_SETTLE_CYC = 2;
    localparam int unsigned CNT_W = 5;
    localparam logic [CNT_W-1:0] WAKE_LAST = 5'(WAKE_SETTLE_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO  = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE   = 5'h01;

    // =====================================================================
    // Operating states.
    typedef enum logic [1:0] {
        PDC_RUN  = 2'b00,
        PDC_DOWN = 2'b01,
        PDC_WAKE = 2'b10
    } pdc_state_t;

endpackage

// *** pdc_hold_if.sv ***
// Interface between the power-down controller and its pin sampler.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none

interface pdc_hold_if;
    import pdc_pkg::*;

    logic [PIN_W-1:0] pins;
    logic             hold;
    logic [PIN_W-1:0] live;
    logic [PIN_W-1:0] held;

    modport ctrl (
        output pins,
        output hold,
        input  live,
        input  held
    );

    modport smp (
        input  pins,
        input  hold,
        output live,
        output held
    );
endinterface

`default_nettype wire

// *** pdc_pin_hold.sv ***
// Pin sampler: two-flop synchroniser per pin, then a hold register.
// Assumes pins are asynchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none

module pdc_pin_hold
    import pdc_pkg::*;
(
    input  wire logic  core_clk_i,
    input  wire logic  rst_i,
    pdc_hold_if.smp    hp
);

    logic [PIN_W-1:0] meta_ff;
    logic [PIN_W-1:0] live_ff;
    logic [PIN_W-1:0] held_ff;

    // =====================================================================
    // Synchroniser.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            live_ff <= '0;
        end else begin
            meta_ff <= hp.pins;
            live_ff <= meta_ff;
        end
    end

    // =====================================================================
    // Hold latch: keeps the last level seen before the freeze.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            held_ff <= '0;
        end else if (!hp.hold) begin
            held_ff <= live_ff;
        end
    end

    assign hp.live = live_ff;
    assign hp.held = held_ff;

endmodule

`default_nettype wire

// *** pdc_top.sv ***
// Pin-controlled power-down controller for a small programmable logic device.
// Assumes the logic fabric honours freeze_o by holding all of its registers.
`timescale 1ns/1ps
`default_nettype none

module pdc_top
    import pdc_pkg::*;
(
    input  wire logic                core_clk_i,
    input  wire logic                rst_i,
    input  wire logic [PD_NUM-1:0]   pd_enable_i,
    input  wire logic [IO_W-1:0]     io_pin_i,
    input  wire logic [DED_W-1:0]    ded_pin_i,
    input  wire logic [IO_W-1:0]     core_out_i,
    input  wire logic [IO_W-1:0]     core_oe_i,
    output logic      [IO_W-1:0]     io_pin_o,
    output logic      [IO_W-1:0]     io_pin_oe_o,
    output logic      [PIN_W-1:0]    arr_in_o,
    output logic      [PIN_W-1:0]    keep_level_o,
    output logic                     freeze_o,
    output logic                     power_down_o
);

    pdc_hold_if hp ();

    pdc_state_t        state_ff;
    pdc_state_t        nxt_state;
    logic [CNT_W-1:0]  wake_cnt_ff;
    logic              power_down_pin;
    logic              frozen;
    logic [PIN_W-1:0]  pd_mask;

    // =====================================================================
    // Functions.
    function automatic logic [PIN_W-1:0] pd_pin_mask(input logic [PD_NUM-1:0] en);
        logic [PIN_W-1:0] m;
        m = '0;
        m[PD1_IDX] = en[0];
        m[PD2_IDX] = en[1];
        return m;
    endfunction

    // =====================================================================
    // Pin sampling.
    assign hp.pins = {ded_pin_i, io_pin_i};
    assign hp.hold = frozen;

    pdc_pin_hold u_hold (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .hp         (hp)
    );

    // =====================================================================
    // Power-down pin decode.
    assign pd_mask = pd_pin_mask(pd_enable_i);
    assign power_down_pin = |(hp.live & pd_mask);

    // Freeze acts in the same cycle the pin is first seen high.
    assign frozen = power_down_pin || (state_ff != PDC_RUN);

    // =====================================================================
    // State machine.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PDC_RUN: begin
                if (power_down_pin) begin
                    nxt_state = PDC_DOWN;
                end
            end
            PDC_DOWN: begin
                if (!power_down_pin) begin
                    nxt_state = PDC_WAKE;
                end
            end
            PDC_WAKE: begin
                if (power_down_pin) begin
                    nxt_state = PDC_DOWN;
                end else if (wake_cnt_ff == WAKE_LAST) begin
                    nxt_state = PDC_RUN;
                end
            end
            default: begin
                nxt_state = PDC_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_ff <= PDC_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Settle counter keeps the freeze for two cycles after the pin falls; the hold register resamples only after release.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wake_cnt_ff <= CNT_ZERO;
        end else if (state_ff == PDC_WAKE && !power_down_pin) begin
            wake_cnt_ff <= wake_cnt_ff + CNT_ONE;
        end else begin
            wake_cnt_ff <= CNT_ZERO;
        end
    end

    // =====================================================================
    // Status and fabric freeze.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            freeze_o     <= 1'b0;
            power_down_o <= 1'b0;
        end else begin
            freeze_o     <= frozen;
            power_down_o <= (nxt_state == PDC_DOWN);
        end
    end

    // =====================================================================
    // Output drivers: held values and enables while frozen.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            io_pin_o    <= '0;
            io_pin_oe_o <= '0;
        end else if (!frozen) begin
            io_pin_o    <= core_out_i;
            io_pin_oe_o <= core_oe_i & ~pd_mask[IO_W-1:0];
        end
        // Else both hold, so high-impedance pins stay undriven.
    end

    // =====================================================================
    // Array inputs: held at the held pin values while frozen, power-down pin never routed.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            arr_in_o <= '0;
        end else begin
            arr_in_o <= hp.held & ~pd_mask;
        end
    end

    // Keeper levels follow the held pin values at all times.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            keep_level_o <= '0;
        end else begin
            keep_level_o <= hp.held;
        end
    end

endmodule

`default_nettype wire

// *** pdc_assertions.sv ***
// Port checks for the power-down controller.
// Assumes it is bound to pdc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pdc_assertions
    import pdc_pkg::*;
(
    input wire logic              core_clk_i,
    input wire logic              rst_i,
    input wire logic [PD_NUM-1:0] pd_enable_i,
    input wire logic [IO_W-1:0]   io_pin_i,
    input wire logic [IO_W-1:0]   io_pin_o,
    input wire logic [IO_W-1:0]   io_pin_oe_o,
    input wire logic [PIN_W-1:0]  arr_in_o,
    input wire logic [PIN_W-1:0]  keep_level_o,
    input wire logic              freeze_o,
    input wire logic              power_down_o
);
    // ==========================================================
    // Checks.
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    wire logic pd_any = |(pd_enable_i & {io_pin_i[PD2_IDX], io_pin_i[PD1_IDX]});
    chk_pd1_blocked: assert property (pd_enable_i[0] && $past(pd_enable_i[0])
        |-> !arr_in_o[PD1_IDX] && !io_pin_oe_o[PD1_IDX]) else $error("Pin one leaked.");
    chk_pd2_blocked: assert property (pd_enable_i[1] && $past(pd_enable_i[1])
        |-> !arr_in_o[PD2_IDX] && !io_pin_oe_o[PD2_IDX]) else $error("Pin two leaked.");
    chk_hold_outputs: assert property (power_down_o && $past(power_down_o)
        |-> $stable(io_pin_o) && $stable(io_pin_oe_o)) else $error("Outputs moved.");
    // Array inputs trail the hold register by one stage, so they settle one cycle later.
    chk_hold_inputs: assert property (power_down_o && $past(power_down_o)
        && $past(power_down_o, 2)
        |-> $stable(arr_in_o) && $stable(keep_level_o)) else $error("Inputs moved.");
    chk_enter_bound: assert property ($rose(pd_any) |-> ##[1:4] freeze_o)
        else $error("Late capture.");
    chk_wake_bound: assert property ($fell(pd_any) |-> ##[1:25] !freeze_o)
        else $error("Late wake.");
    chk_freeze_with: assert property ($rose(power_down_o) |-> freeze_o)
        else $error("Freeze missing.");
    chk_off_inert: assert property ((pd_enable_i == 2'b00) [*3] |-> !power_down_o)
        else $error("Disabled pin acted.");
    cover property ($rose(power_down_o) && pd_enable_i[0]);
    cover property ($rose(power_down_o) && pd_enable_i[1]);
    cover property ($fell(freeze_o));
endmodule
bind pdc_top pdc_assertions u_chk (.core_clk_i, .rst_i, .pd_enable_i, .io_pin_i, .io_pin_o,
    .io_pin_oe_o, .arr_in_o, .keep_level_o, .freeze_o, .power_down_o);
`default_nettype wire

// *** pdc_board.sv ***
// Board model driving the pins of the power-down controller.
// Assumes the bench supplies fresh levels and the power-down level.
`timescale 1ns/1ps
`default_nettype none
module pdc_board
    import pdc_pkg::*;
(
    input  wire logic             core_clk_i,
    input  wire logic             keep_i,
    input  wire logic             pd_lvl_i,
    input  wire logic [PIN_W-1:0] nxt_i,
    output logic      [PIN_W-1:0] pins_o
);
    // ==========================================================
    // Pin drive, steady while keep_i is high, except the two power-down pins, which always follow pd_lvl_i.
    always_ff @(negedge core_clk_i) begin
        if (!keep_i) begin
            pins_o <= nxt_i;
        end
        pins_o[PD1_IDX] <= pd_lvl_i;
        pins_o[PD2_IDX] <= pd_lvl_i;
    end
endmodule
`default_nettype wire

// *** test_pin_power_down_control.sv ***
// Bench for the power-down controller with board model and checker.
// Assumes the design files and pdc_board are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_pin_power_down_control;
    import pdc_pkg::*;
    logic             clk, rst, keep, pd_lvl, frz, pdn;
    logic [1:0]       en;
    logic [IO_W-1:0]  cout, coe, c_o, c_e, pin_o, pin_oe;
    logic [PIN_W-1:0] nxt, pins, p, msk, arr, lvl;
    int               n_mismatch, checks, cyc, seed, n;
    pdc_board brd (.core_clk_i(clk), .keep_i(keep), .pd_lvl_i(pd_lvl), .nxt_i(nxt), .pins_o(pins));
    pdc_top uut (.core_clk_i(clk), .rst_i(rst), .pd_enable_i(en), .io_pin_i(pins[IO_W-1:0]),
        .ded_pin_i(pins[PIN_W-1:IO_W]), .core_out_i(cout), .core_oe_i(coe), .io_pin_o(pin_o),
        .io_pin_oe_o(pin_oe), .arr_in_o(arr), .keep_level_o(lvl), .freeze_o(frz),
        .power_down_o(pdn));
    // ==========================================================
    // Compare, stimulus and closing tasks.
    task automatic chk(input logic [PIN_W-1:0] got, input logic [PIN_W-1:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic step(input int k, input logic hold);
        repeat (k) begin
            @(negedge clk);
            keep <= hold;
            if (!hold) begin
                cout = $random(seed);
                coe = $random(seed);
                nxt <= PIN_W'({$random(seed), $random(seed)});
            end
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // Clock, time limit and scenarios.
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        seed = 32'h65605329;
        rst = 1; keep = 0; pd_lvl = 0; en = 0; nxt = '0; cout = '0; coe = '0;
        step(4, 0);
        rst = 0;
        for (int m = 0; m < 3; m++) begin
            en = 2'(m);
            msk = (m == 1) ? (PIN_W'(1) << PD1_IDX) : (m == 2) ? (PIN_W'(1) << PD2_IDX) : '0;
            step(6, 0);
            step(4, 1);
            p = pins; c_o = cout; c_e = coe;
            pd_lvl <= 1'b1;
            step(5, 1);
            chk(frz, m != 0);
            chk(pdn, m != 0);
            if (m == 0) chk(arr, pins);
            step(6, 0);
            if (m != 0) begin
                chk(pin_o, c_o);
                chk(pin_oe, c_e & ~msk[IO_W-1:0]);
                chk(arr, p & ~msk);
                chk(lvl, p);
            end
            pd_lvl <= 1'b0;
            n = 0;
            while (frz !== 1'b0 && n < 30) begin
                step(1, 1);
                n++;
            end
            chk(n <= 25, 1);
            chk(pdn, 0);
            step(2, 0);
            step(5, 1);
            chk(pin_o, cout);
            chk(pin_oe, coe & ~msk[IO_W-1:0]);
            chk(arr, pins & ~msk);
        end
        stop_test();
    end
endmodule
`default_nettype wire
